// [logic/dcodp_top.sv]
// module: top of the dual current output data path
`timescale 1ns/1ps
// Summary of operation
// - zero current until startup completes
// - comm loss forces fallback until restored
// - fallback is fixed 4 mA both channels
// - two adjacent words, one per channel
// - code taken from word bits 14..5
// - current linear: count 0 4 mA, 32000 20 mA
// - above 32000 accepted, no over-range flag
// - no parameters, no reflexes, words only
// - interface module writes words from master
module dcodp_top (
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic        startup_done,
   input  wire logic        comm_ok,
   input  wire logic [15:0] word_ch0,
   input  wire logic [15:0] word_ch1,
   input  wire logic        word_load,
   output logic [9:0]       dac_code_ch0,
   output logic [9:0]       dac_code_ch1,
   output logic             zero_current_ch0,
   output logic             zero_current_ch1,
   output logic             operational,
   output logic             fallback_active
);
   // ****************************************
   // mode control
   // ****************************************
   dcodp_pkg::dcodp_state_t state;
   dcodp_pkg::dcodp_state_t next_state;

   // startup holds until done; fallback tracks comm loss
   always_comb begin
      next_state = state;
      unique case (state)
         dcodp_pkg::DCODP_STARTUP: begin
            if (startup_done) begin
               next_state = comm_ok ? dcodp_pkg::DCODP_RUN
                                    : dcodp_pkg::DCODP_FALLBACK;
            end
         end
         dcodp_pkg::DCODP_RUN: begin
            if (!comm_ok) begin
               next_state = dcodp_pkg::DCODP_FALLBACK;
            end
         end
         dcodp_pkg::DCODP_FALLBACK: begin
            if (comm_ok) begin
               next_state = dcodp_pkg::DCODP_RUN;
            end
         end
         // an illegal code restarts the mode control from startup
         default: begin
            next_state = dcodp_pkg::DCODP_STARTUP;
         end
      endcase
   end

   // reset lands in startup, so both outputs begin at zero current;
   // the master cannot move them until startup has been reported
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state <= dcodp_pkg::DCODP_STARTUP;
      end else begin
         state <= next_state;
      end
   end

   // status flags registered alongside the state; both lag the state
   // by one edge, like the codes they describe
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         operational     <= 1'b0;
         fallback_active <= 1'b0;
      end else begin
         operational     <= (state != dcodp_pkg::DCODP_STARTUP);
         fallback_active <= (state == dcodp_pkg::DCODP_FALLBACK);
      end
   end

   // ****************************************
   // channels
   // ****************************************
   // both words arrive on one strobe; a word loaded in fallback is
   // still stored, so the latest master value returns with the link
   logic [15:0] word_in  [dcodp_pkg::NUM_CHANNELS];
   logic [9:0]  code_out [dcodp_pkg::NUM_CHANNELS];
   logic        zero_out [dcodp_pkg::NUM_CHANNELS];

   // first word of the pair feeds channel 0, the next channel 1
   assign word_in[0] = word_ch0;
   assign word_in[1] = word_ch1;

   // one slice per channel; the mode is shared so both move together
   // and nothing local tunes them, only the words and the mode
   // trade-off: no per-channel fallback, the link is one for both
   for (genvar i = 0; i < dcodp_pkg::NUM_CHANNELS; i++) begin : g_ch
      dcodp_word_if wr_if ();
      assign wr_if.word = word_in[i];
      assign wr_if.load = word_load;
      dcodp_channel u_dcodp_channel (
         .ref_clk      (ref_clk),
         .sys_rst      (sys_rst),
         .wr           (wr_if),
         .state        (state),
         .code         (code_out[i]),
         .zero_current (zero_out[i])
      );
   end

   // top outputs are the channel registers, wired with no logic
   assign dac_code_ch0     = code_out[0];
   assign dac_code_ch1     = code_out[1];
   assign zero_current_ch0 = zero_out[0];
   assign zero_current_ch1 = zero_out[1];

   // ****************************************
   // build checks
   // ****************************************
   // the pin list serves two channels of 16-bit words and 10-bit codes
   // anything else would need new ports, not just new constants
   if (dcodp_pkg::NUM_CHANNELS != 2) begin : g_bad_channels
      $error("channel count does not match the pin list");
   end
   if (dcodp_pkg::WORD_WIDTH != $bits(word_ch0)) begin : g_bad_word
      $error("word width does not match the pin list");
   end
   if (dcodp_pkg::CODE_WIDTH != $bits(dac_code_ch0)) begin : g_bad_code
      $error("code width does not match the pin list");
   end
   // the field must sit inside the word and fill the code exactly
   if (dcodp_pkg::CODE_MSB >= dcodp_pkg::WORD_WIDTH
       || dcodp_pkg::CODE_MSB - dcodp_pkg::CODE_LSB + 1
          != dcodp_pkg::CODE_WIDTH) begin : g_bad_field
      $error("code field does not fit the word or the code");
   end

   // ****************************************
   // checks
   // ****************************************
   chk_startup_zero: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (state == dcodp_pkg::DCODP_STARTUP) |=> zero_current_ch0
         && zero_current_ch1 && dac_code_ch0 == 10'h000
         && dac_code_ch1 == 10'h000)
      else $error("outputs not zero during startup");
   // link loss and link return each show within two edges
   chk_fallback_entry: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (operational && !comm_ok) |-> ##[1:2] fallback_active)
      else $error("fallback not entered on comm loss");
   chk_fallback_code: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (state == dcodp_pkg::DCODP_FALLBACK) |=>
         (dac_code_ch0 == 10'h000 && dac_code_ch1 == 10'h000
          && !zero_current_ch0
          && !zero_current_ch1))
      else $error("fallback code not 4 mA");
   // a load in run shows on the code two edges later
   chk_code_bits: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (state == dcodp_pkg::DCODP_RUN && word_load
       && next_state == dcodp_pkg::DCODP_RUN) |=> ##1
         (dac_code_ch1 == $past(word_ch1[14:5], 2)))
      else $error("code not from bits 14..5");
   chk_ignore_bits: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (state == dcodp_pkg::DCODP_RUN && word_load
       && next_state == dcodp_pkg::DCODP_RUN) |=> ##1
         (dac_code_ch0 == $past(word_ch0[14:5], 2)))
      else $error("code affected by ignored bits");
   // counts past full scale (code 1000) pass through with no flag
   chk_over_range: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (state == dcodp_pkg::DCODP_RUN && comm_ok && word_load
       && word_ch1[14:5] > 10'h3e8) |=> ##1
         (dac_code_ch1 == $past(word_ch1[14:5], 2)
          && !fallback_active && !zero_current_ch1))
      else $error("over-range count flagged or altered");
   // once the link is back the fallback flag must drop
   chk_restore_run: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (fallback_active && comm_ok) |-> ##[1:2] !fallback_active)
      else $error("fallback held after comm restored");
   chk_linear_zero: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (state == dcodp_pkg::DCODP_RUN && word_load
       && word_ch0[14:5] == 10'h000
       && next_state == dcodp_pkg::DCODP_RUN) |=> ##1
         (dac_code_ch0 == 10'h000))
      else $error("count zero not mapped to 4 mA code");

   // ****************************************
   // status and hold checks
   // ****************************************
   // startup shows no status at all, only zero current
   chk_startup_flags: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (state == dcodp_pkg::DCODP_STARTUP) |=>
         (!operational && !fallback_active))
      else $error("status raised during startup");
   // link still down: fallback must not be left
   chk_fallback_hold: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (state == dcodp_pkg::DCODP_FALLBACK && !comm_ok) |=>
         (state == dcodp_pkg::DCODP_FALLBACK))
      else $error("fallback left while link down");
   // while flagged, both channels sit at the fixed 4 mA code
   chk_fallback_both: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      fallback_active |-> (dac_code_ch0 == dcodp_pkg::FALLBACK_CODE
         && dac_code_ch1 == dcodp_pkg::FALLBACK_CODE
         && !zero_current_ch1))
      else $error("fallback code differs from 4 mA");
   // with no load a running code never moves on its own; a drift
   // here would mean some local action moved the output
   chk_hold_code_ch0: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (state == dcodp_pkg::DCODP_RUN && !$past(word_load)
       && $past(state) == dcodp_pkg::DCODP_RUN) |=>
         $stable(dac_code_ch0))
      else $error("channel 0 code moved without a word");
   chk_hold_code_ch1: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (state == dcodp_pkg::DCODP_RUN && !$past(word_load)
       && $past(state) == dcodp_pkg::DCODP_RUN) |=>
         $stable(dac_code_ch1))
      else $error("channel 1 code moved without a word");
endmodule : dcodp_top

// [logic/dcodp_pkg.sv]
// package: constants and types for the dual current output data path
package dcodp_pkg;
   localparam int unsigned NUM_CHANNELS    = 2;
   localparam int unsigned WORD_WIDTH      = 16;
   localparam int unsigned CODE_WIDTH      = 10;
   localparam int unsigned CODE_MSB        = 14;
   localparam int unsigned CODE_LSB        = 5;
   // converter code that yields 4 mA (word count 0 -> code 0)
   localparam logic [9:0]  FALLBACK_CODE   = 10'h000;
   // converter code reset value while not yet operational
   localparam logic [9:0]  RESET_CODE      = 10'h000;
   typedef enum logic [1:0] {
      DCODP_STARTUP,
      DCODP_RUN,
      DCODP_FALLBACK
   } dcodp_state_t;
endpackage : dcodp_pkg

// [logic/dcodp_word_if.sv]
// interface: one channel's output word with its write strobe
`timescale 1ns/1ps
interface dcodp_word_if;
   logic [15:0] word;
   logic        load;
   modport src (output word, output load);
   modport dst (input  word, input  load);
endinterface : dcodp_word_if

// [logic/dcodp_channel.sv]
// module: one channel's code extraction and output hold register
`timescale 1ns/1ps
module dcodp_channel (
   input  wire logic                ref_clk,
   input  wire logic                sys_rst,
   dcodp_word_if.dst                wr,
   input  wire dcodp_pkg::dcodp_state_t state,
   output logic [9:0]               code,
   output logic                     zero_current
);
   logic [9:0] held;

   // latest accepted word field; bit 15 and bits 4..0 dropped
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         held <= dcodp_pkg::RESET_CODE;
      end else if (wr.load) begin
         held <= wr.word[dcodp_pkg::CODE_MSB:dcodp_pkg::CODE_LSB];
      end
   end

   // code to converter; values over full scale pass unflagged
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         code         <= dcodp_pkg::RESET_CODE;
         zero_current <= 1'b1;
      end else begin
         unique case (state)
            dcodp_pkg::DCODP_STARTUP: begin
               code         <= dcodp_pkg::RESET_CODE;
               zero_current <= 1'b1;
            end
            dcodp_pkg::DCODP_FALLBACK: begin
               code         <= dcodp_pkg::FALLBACK_CODE;
               zero_current <= 1'b0;
            end
            dcodp_pkg::DCODP_RUN: begin
               code         <= held;
               zero_current <= 1'b0;
            end
            // illegal mode code: safest output is zero current
            default: begin
               code         <= dcodp_pkg::RESET_CODE;
               zero_current <= 1'b1;
            end
         endcase
      end
   end
endmodule : dcodp_channel

// [bench/dcodp_island_model.sv]
// partner: island network interface model feeding both output words
`timescale 1ns/1ps
module dcodp_island_model (
   input  wire logic        ref_clk,
   input  wire logic        send,
   input  wire logic [15:0] next_w0,
   input  wire logic [15:0] next_w1,
   output logic [15:0]      word_ch0 = 16'h0000,
   output logic [15:0]      word_ch1 = 16'h0000,
   output logic             word_load = 1'b0
);
   // idle words toggle so a stale value is never mistaken for a load
   always_ff @(posedge ref_clk) begin
      word_load <= send;
      word_ch0  <= send ? next_w0 : ~word_ch0;
      word_ch1  <= send ? next_w1 : ~word_ch1;
   end
endmodule : dcodp_island_model

// [bench/dcodp_top_tb.sv]
// testbench: dual current output data path against a bench model
`timescale 1ns/1ps
module dcodp_top_tb;
   logic        ref_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        startup_done = 1'b0;
   logic        comm_ok = 1'b1;
   logic        send = 1'b0;
   logic [15:0] w0 = 16'h0000;
   logic [15:0] w1 = 16'h0000;
   logic [15:0] word_ch0;
   logic [15:0] word_ch1;
   logic        word_load;
   logic [9:0]  code0;
   logic [9:0]  code1;
   logic        zc0;
   logic        zc1;
   logic        oper;
   logic        fb;
   int          errors = 0;
   int          checked = 0;
   int          held0 = 0;
   int          held1 = 0;
   always #2 ref_clk = ~ref_clk;
   dcodp_island_model u_dcodp_island_model (.ref_clk(ref_clk), .send(send),
      .next_w0(w0), .next_w1(w1), .word_ch0(word_ch0),
      .word_ch1(word_ch1), .word_load(word_load));
   dcodp_top u_dcodp_top (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .startup_done(startup_done), .comm_ok(comm_ok), .word_ch0(word_ch0),
      .word_ch1(word_ch1), .word_load(word_load), .dac_code_ch0(code0),
      .dac_code_ch1(code1), .zero_current_ch0(zc0), .zero_current_ch1(zc1),
      .operational(oper), .fallback_active(fb));
   // ****************
   // shared tasks
   // ****************
   task check(input logic [9:0] seen, input logic [9:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check
   // model: codes only pass in run, fallback code is the 4 mA count 0
   task expect_now;
      logic run;
      run = startup_done && comm_ok;
      check(code0, run ? 10'(held0) : 10'h000);
      check(code1, run ? 10'(held1) : 10'h000);
      check({9'h000, zc0}, {9'h000, !startup_done});
      check({9'h000, zc1}, {9'h000, !startup_done});
      check({9'h000, oper}, {9'h000, startup_done});
      check({9'h000, fb}, {9'h000, startup_done && !comm_ok});
   endtask : expect_now
   task load(input logic [15:0] a, input logic [15:0] b);
      @(posedge ref_clk);
      send <= 1'b1;
      w0   <= a;
      w1   <= b;
      @(posedge ref_clk);
      send  <= 1'b0;
      held0 = (a >> 5) & 1023;
      held1 = (b >> 5) & 1023;
      repeat (4) @(posedge ref_clk);
      #1 expect_now;
   endtask : load
   task mode(input logic s, input logic c);
      @(posedge ref_clk);
      startup_done <= s;
      comm_ok      <= c;
      repeat (3) @(posedge ref_clk);
      #1 expect_now;
   endtask : mode
   task results;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : results
   // bounded run: a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      results;
   end
   initial begin
      void'($urandom(71));
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      #1 expect_now;
      load(16'h801f, 16'h001f);
      $display("test startup hold done");
      mode(1'b1, 1'b1);
      load(16'h7d00, 16'h7fe0);
      for (int i = 0; i < 24; i++) begin
         load(16'($urandom), 16'($urandom));
      end
      $display("test run words done");
      mode(1'b1, 1'b0);
      load(16'($urandom), 16'($urandom));
      mode(1'b1, 1'b1);
      $display("test fallback done");
      // back to back loads, the later pair must win
      @(posedge ref_clk);
      send <= 1'b1;
      w0   <= 16'h1234;
      w1   <= 16'h4321;
      @(posedge ref_clk);
      w0   <= 16'h6ac0;
      w1   <= 16'h0fe0;
      @(posedge ref_clk);
      send <= 1'b0;
      held0 = 16'h6ac0 >> 5;
      held1 = 16'h0fe0 >> 5;
      repeat (4) @(posedge ref_clk);
      #1 expect_now;
      $display("test back to back done");
      // reset again mid-run, then start up with the link down
      @(posedge ref_clk);
      sys_rst      <= 1'b1;
      startup_done <= 1'b0;
      @(posedge ref_clk);
      sys_rst <= 1'b0;
      held0 = 0;
      held1 = 0;
      #1 expect_now;
      mode(1'b1, 1'b0);
      $display("test restart done");
      results;
   end
endmodule : dcodp_top_tb
